// *** dv/pfsw_cpu_model.sv ***
// Bus-master stand-in for the CPU core issuing register and table accesses
`timescale 1ns/1ps
`default_nettype none
`include "pfsw_defines.svh"

module pfsw_cpu_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             rdv,
    output logic [31:0]      rdq
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
        rdv    = 1'b0;
        rdq    = 32'h0;
    end

    // Waits as long as hready stays low; a stall simply stretches the phase
    task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, ofs};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        if (!w) begin
            rdq <= hrdata;
            rdv <= 1'b1;
            @(posedge clk);
            rdv <= 1'b0;
        end
    endtask : xfer

    // Set up control, unlock and start; an optional stray write breaks the unlock
    task automatic launch(input logic [15:0] ctrl, input bit intrude);
        xfer(1'b1, `PFSW_OFS_CTRL, {16'h0, ctrl & 16'h7fff});
        xfer(1'b1, `PFSW_OFS_KEY, 32'h55);
        if (intrude) xfer(1'b1, `PFSW_OFS_PAGE, 32'h0);
        xfer(1'b1, `PFSW_OFS_KEY, 32'haa);
        xfer(1'b1, `PFSW_OFS_CTRL, {16'h0, ctrl});
    endtask : launch
endmodule : pfsw_cpu_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pfsw_defines.svh"

module tb;
    localparam int OPC = 20;
    logic        clk;
    logic        arst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        cpu_stall;
    logic        rdv;
    logic [31:0] rdq;
    logic [31:0] expq[$];
    logic [15:0] lo[32];
    logic [7:0]  hi[32];
    logic [7:0]  pg;
    logic [15:0] base;
    int          err_total;
    int          comparisons;
    int          n;

    pfsw_top #(.OP_CYCLES(OPC)) dut_u (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cpu_stall(cpu_stall));

    pfsw_cpu_model m_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .rdv(rdv), .rdq(rdq));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
        expq.push_back(exp);
        m_u.xfer(1'b0, ofs, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        m_u.xfer(1'b1, ofs, d);
    endtask : wr

    // Counts stall cycles after the start write; a refused start shows none
    task automatic go(input logic [15:0] c, input bit ix, input bit ok);
        m_u.launch(c, ix);
        n = 0;
        while (cpu_stall === 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), ok ? 32'(OPC) : 32'h0);
    endtask : go

    task automatic target(input logic [15:0] a);
        wr(`PFSW_OFS_ADDR_LOW, {16'h0, a});
        wr(`PFSW_OFS_ADDR_HIGH, {24'h0, pg});
    endtask : target

    always @(posedge clk) begin
        if (rdv === 1'b1) begin
            chk(rdq, expq.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #(3_000_000);
        err_total++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        err_total = 0;
        comparisons = 0;
        void'($urandom(58516));
        pg = 8'($urandom());
        base = {2'b0, 8'($urandom()), 6'h0};
        foreach (lo[i]) begin
            lo[i] = 16'($urandom());
            hi[i] = 8'($urandom());
        end
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(`PFSW_OFS_CTRL, 32'h0);
        rd(`PFSW_OFS_KEY, 32'h0);
        wr(8'h20, 32'hffff);
        rd(8'h20, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            target(base ^ (16'(k) << 6));
            go(16'hc041, 1'b0, 1'b1);
        end
        rd(`PFSW_OFS_CTRL, 32'h4041);
        $display("test erase done");
        wr(`PFSW_OFS_PAGE, {24'h0, pg});
        // Ascending fill, upper three source bytes of the high write are junk
        for (int i = 0; i < 32; i++) begin
            wr(`PFSW_OFS_TBL_EA, {16'h0, base + 16'(2 * i)});
            wr(`PFSW_OFS_TBL_LOW, {16'h0, lo[i]});
            wr(`PFSW_OFS_TBL_HIGH, {16'($urandom()), 8'($urandom()), hi[i]});
        end
        rd(`PFSW_OFS_ADDR_LOW, {16'h0, base + 16'd62});
        rd(`PFSW_OFS_ADDR_HIGH, {24'h0, pg});
        rd(`PFSW_OFS_TBL_LOW, 32'hffff);
        go(16'hc001, 1'b0, 1'b1);
        for (int i = 0; i < 32; i++) begin
            wr(`PFSW_OFS_TBL_EA, {16'h0, base + 16'(2 * i)});
            rd(`PFSW_OFS_TBL_LOW, {16'h0, lo[i]});
            rd(`PFSW_OFS_TBL_HIGH, {24'h0, hi[i]});
        end
        wr(`PFSW_OFS_TBL_EA, {15'h0, 1'b1, base | 16'h1});
        rd(`PFSW_OFS_TBL_LOW, {24'h0, lo[0][15:8]});
        rd(`PFSW_OFS_TBL_HIGH, 32'h0);
        $display("test program done");
        // Byte-wide low-latch writes land in word 0 and the odd high write is dropped, then the neighbour row is programmed
        wr(`PFSW_OFS_TBL_EA, {15'h0, 1'b1, base});
        wr(`PFSW_OFS_TBL_LOW, {24'h0, hi[29]});
        wr(`PFSW_OFS_TBL_EA, {15'h0, 1'b1, base | 16'h1});
        wr(`PFSW_OFS_TBL_LOW, {24'h0, hi[31]});
        wr(`PFSW_OFS_TBL_HIGH, {24'h0, hi[30]});
        target(base ^ 16'h40);
        go(16'hc001, 1'b0, 1'b1);
        wr(`PFSW_OFS_TBL_EA, {16'h0, base ^ 16'h40});
        rd(`PFSW_OFS_TBL_LOW, {16'h0, hi[31], hi[29]});
        rd(`PFSW_OFS_TBL_HIGH, {24'h0, hi[0]});
        // Erasing the neighbour row must clear it and leave ours intact
        target(base ^ 16'h40);
        go(16'hc041, 1'b0, 1'b1);
        wr(`PFSW_OFS_TBL_EA, {16'h0, base ^ 16'h4a});
        rd(`PFSW_OFS_TBL_HIGH, 32'hff);
        target(base);
        go(16'hc041, 1'b1, 1'b0);
        rd(`PFSW_OFS_CTRL, 32'h6041);
        go(16'h8041, 1'b0, 1'b0);
        rd(`PFSW_OFS_CTRL, 32'h2041);
        wr(`PFSW_OFS_CTRL, 32'h0);
        rd(`PFSW_OFS_CTRL, 32'h0);
        wr(`PFSW_OFS_TBL_EA, {16'h0, base});
        rd(`PFSW_OFS_TBL_LOW, {16'h0, lo[0]});
        $display("test refusal done");
        repeat (3) @(posedge clk);
        test_done();
    end
endmodule : tb
`default_nettype wire

// *** pkg/pfsw_defines.svh ***
// Register offsets, field positions, keys and timing for the self-programming block
`ifndef PFSW_DEFINES_SVH
`define PFSW_DEFINES_SVH

// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define PFSW_OFS_CTRL      8'h00
`define PFSW_OFS_ADDR_LOW  8'h04
`define PFSW_OFS_ADDR_HIGH 8'h08
`define PFSW_OFS_KEY       8'h0c
`define PFSW_OFS_PAGE      8'h10
`define PFSW_OFS_TBL_EA    8'h14
`define PFSW_OFS_TBL_LOW   8'h18
`define PFSW_OFS_TBL_HIGH  8'h1c

// --------------------------------------------------------------------
// Fields, keys, opcodes
// --------------------------------------------------------------------
`define PFSW_START_BIT     15
`define PFSW_WRITE_ENABLE_BIT_BIT      14
`define PFSW_ERR_BIT       13
`define PFSW_EA_BYTE_BIT   16
`define PFSW_KEY_FIRST     8'h55
`define PFSW_KEY_SECOND    8'haa
`define PFSW_OP_ERASE_ROW  7'h41
`define PFSW_OP_PROG_ROW   7'h01
`define PFSW_CTRL_RESET    16'h0000
`define PFSW_ERASED_WORD   24'hffffff

// --------------------------------------------------------------------
// Array geometry and timing
// --------------------------------------------------------------------
`define PFSW_ROW_WORDS     32
`define PFSW_ROW_BYTES     96
`define PFSW_PANEL_ROWS    128
`define PFSW_PANELS        2
`define PFSW_ARRAY_WORDS   8192
`define PFSW_OP_TIME_US    2000
`define PFSW_CLK_KHZ       10000

`endif

// *** pkg/pfsw_pkg.sv ***
// Types shared by the self-programming block
package pfsw_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } pfsw_seq_e;

    typedef enum logic [2:0] {
        KEY_NONE  = 3'b001,
        KEY_HALF  = 3'b010,
        KEY_ARMED = 3'b100
    } pfsw_key_e;

    typedef struct packed {
        logic       start;
        logic       write_enable_bit;
        logic       err;
        logic [5:0] rsvd;
        logic [6:0] op;
    } pfsw_ctrl_s;

    typedef struct packed {
        logic       write;
        logic [7:0] ofs;
    } pfsw_aphase_s;

endpackage : pfsw_pkg

// *** rtl/pfsw_top.sv ***
// Run-time self-programming sequencer for program flash, AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "pfsw_defines.svh"

module pfsw_top #(
    parameter int OP_CYCLES = `PFSW_OP_TIME_US * `PFSW_CLK_KHZ / 1000
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             cpu_stall
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pfsw_pkg::pfsw_ctrl_s   flash_control_reg;
    pfsw_pkg::pfsw_key_e    key_st;
    pfsw_pkg::pfsw_seq_e    seq;
    pfsw_pkg::pfsw_aphase_s ap;
    logic                   pend;
    logic [15:0]            flash_addr_low_reg;
    logic [7:0]             flash_addr_high_reg;
    logic [7:0]             table_page_pointer;
    logic [15:0]            tbl_ea;
    logic                   tbl_byte;
    logic [31:0]            busy_cnt;
    logic [23:0]            wr_latch [0:`PFSW_PANELS-1][0:`PFSW_ROW_WORDS-1];
    logic [23:0]            flash_mem [0:`PFSW_ARRAY_WORDS-1];

    function automatic logic [7:0] row_of(input logic [23:0] a);
        row_of = a[13:6];
    endfunction : row_of

    function automatic logic panel_of(input logic [23:0] a);
        panel_of = a[13];
    endfunction : panel_of

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire        accept    = hsel & htrans[1] & hready;
    wire        do_acc    = pend & (seq == pfsw_pkg::SEQ_IDLE);
    wire        wr        = do_acc & ap.write;
    wire        rd        = do_acc & ~ap.write;
    wire        sel_ctrl  = ap.ofs == `PFSW_OFS_CTRL;
    wire        sel_alo   = ap.ofs == `PFSW_OFS_ADDR_LOW;
    wire        sel_ahi   = ap.ofs == `PFSW_OFS_ADDR_HIGH;
    wire        sel_key   = ap.ofs == `PFSW_OFS_KEY;
    wire        sel_page  = ap.ofs == `PFSW_OFS_PAGE;
    wire        sel_ea    = ap.ofs == `PFSW_OFS_TBL_EA;
    wire        sel_tlo   = ap.ofs == `PFSW_OFS_TBL_LOW;
    wire        sel_thi   = ap.ofs == `PFSW_OFS_TBL_HIGH;
    wire        tbl_acc   = do_acc & (sel_tlo | sel_thi);
    wire        tbl_wr_lo = wr & sel_tlo;
    wire        tbl_wr_hi = wr & sel_thi;
    wire [23:0] tbl_addr  = {table_page_pointer, tbl_ea};
    wire [23:0] tgt_addr  = {flash_addr_high_reg, flash_addr_low_reg};
    wire        lat_pan   = panel_of(tbl_addr);
    wire [4:0]  lat_idx   = tbl_addr[5:1];
    wire [23:0] lat_cur   = wr_latch[lat_pan][lat_idx];
    wire [23:0] flash_rd  = flash_mem[tbl_addr[13:1]];
    wire        odd_byte  = tbl_byte & tbl_ea[0];

    // Byte mode picks the lane by EA bit 0; the odd high byte is a phantom that reads zero
    wire [15:0] tlo_rd = ~tbl_byte ? flash_rd[15:0] :
                         (tbl_ea[0] ? {8'h00, flash_rd[15:8]} : {8'h00, flash_rd[7:0]});
    wire [15:0] thi_rd = odd_byte ? 16'h0000 : {8'h00, flash_rd[23:16]};

    logic [23:0] next_latch;
    always_comb begin
        next_latch = lat_cur;
        if (tbl_wr_lo) begin
            if (!tbl_byte)
                next_latch[15:0] = hwdata[15:0];
            else if (tbl_ea[0])
                next_latch[15:8] = hwdata[7:0];
            else
                next_latch[7:0] = hwdata[7:0];
        end else if (tbl_wr_hi && !odd_byte) begin
            next_latch[23:16] = hwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Unlock and launch
    // ----------------------------------------------------------------
    wire ctrl_wr    = wr & sel_ctrl;
    wire op_ok      = (hwdata[6:0] == `PFSW_OP_ERASE_ROW) | (hwdata[6:0] == `PFSW_OP_PROG_ROW);
    wire start_req  = ctrl_wr & hwdata[`PFSW_START_BIT];
    wire launch     = start_req & (key_st == pfsw_pkg::KEY_ARMED)
                    & hwdata[`PFSW_WRITE_ENABLE_BIT_BIT] & op_ok;
    wire done       = (seq == pfsw_pkg::SEQ_BUSY) & (busy_cnt == 32'(OP_CYCLES - 1));

    pfsw_pkg::pfsw_key_e next_key;
    assign next_key = !wr                                 ? key_st :
                      (sel_key && hwdata[7:0] == `PFSW_KEY_FIRST) ? pfsw_pkg::KEY_HALF :
                      (sel_key && hwdata[7:0] == `PFSW_KEY_SECOND
                               && key_st == pfsw_pkg::KEY_HALF)   ? pfsw_pkg::KEY_ARMED :
                      pfsw_pkg::KEY_NONE;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            key_st <= pfsw_pkg::KEY_NONE;
        else
            key_st <= next_key;
    end

    // Refused start flags an error; a refusal in the clearing write still sets it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_control_reg <= `PFSW_CTRL_RESET;
        end else if (ctrl_wr) begin
            flash_control_reg.write_enable_bit  <= hwdata[`PFSW_WRITE_ENABLE_BIT_BIT];
            flash_control_reg.op    <= hwdata[6:0];
            flash_control_reg.start <= launch;
            flash_control_reg.err   <= (start_req & ~launch)
                                     | (flash_control_reg.err & hwdata[`PFSW_ERR_BIT]);
        end else if (done) begin
            flash_control_reg.start <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Operation timer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq      <= pfsw_pkg::SEQ_IDLE;
            busy_cnt <= 32'h0000_0000;
        end else begin
            case (seq)
                pfsw_pkg::SEQ_IDLE: begin
                    busy_cnt <= 32'h0000_0000;
                    if (launch)
                        seq <= pfsw_pkg::SEQ_BUSY;
                end
                pfsw_pkg::SEQ_BUSY: begin
                    busy_cnt <= busy_cnt + 32'h0000_0001;
                    if (done)
                        seq <= pfsw_pkg::SEQ_IDLE;
                end
                default: seq <= pfsw_pkg::SEQ_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Address, page and table registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_addr_low_reg  <= 16'h0000;
            flash_addr_high_reg <= 8'h00;
            table_page_pointer  <= 8'h00;
            tbl_ea              <= 16'h0000;
            tbl_byte            <= 1'b0;
        end else begin
            if (tbl_acc) begin
                flash_addr_low_reg  <= tbl_addr[15:0];
                flash_addr_high_reg <= tbl_addr[23:16];
            end else if (wr && sel_alo) begin
                flash_addr_low_reg <= hwdata[15:0];
            end else if (wr && sel_ahi) begin
                flash_addr_high_reg <= hwdata[7:0];
            end
            if (wr && sel_page)
                table_page_pointer <= hwdata[7:0];
            if (wr && sel_ea) begin
                tbl_ea   <= hwdata[15:0];
                tbl_byte <= hwdata[`PFSW_EA_BYTE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Latches and array; neither is reset, as flash contents survive reset
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (tbl_wr_lo || tbl_wr_hi)
            wr_latch[lat_pan][lat_idx] <= next_latch;
    end

    always_ff @(posedge clk) begin
        if (done) begin
            for (int i = 0; i < `PFSW_ROW_WORDS; i++) begin
                if (flash_control_reg.op == `PFSW_OP_ERASE_ROW)
                    flash_mem[{row_of(tgt_addr), 5'(i)}] <= `PFSW_ERASED_WORD;
                else
                    flash_mem[{row_of(tgt_addr), 5'(i)}] <=
                        wr_latch[panel_of(tgt_addr)][i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus slave: one wait state per transfer when idle; while busy the data phase is held until done
    // ----------------------------------------------------------------
    logic [15:0] rd_mux;
    assign rd_mux = sel_ctrl ? flash_control_reg :
                    sel_alo  ? flash_addr_low_reg :
                    sel_ahi  ? {8'h00, flash_addr_high_reg} :
                    sel_page ? {8'h00, table_page_pointer} :
                    sel_ea   ? tbl_ea :
                    sel_tlo  ? tlo_rd :
                    sel_thi  ? thi_rd :
                    16'h0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ap        <= '0;
            pend      <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
            cpu_stall <= 1'b0;
        end else begin
            cpu_stall <= launch | ((seq == pfsw_pkg::SEQ_BUSY) & ~done);
            if (accept) begin
                ap        <= '{write: hwrite, ofs: haddr[7:0]};
                pend      <= 1'b1;
                hreadyout <= 1'b0;
            end else if (do_acc) begin
                pend      <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= rd ? {16'h0000, rd_mux} : 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_KEY_GATE: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(key_st == pfsw_pkg::KEY_ARMED) |-> $past(key_st) == pfsw_pkg::KEY_HALF
            && $past(wr && sel_key && hwdata[7:0] == `PFSW_KEY_SECOND))
        else $error("key armed without the two key writes");

    AST_WRITE_ENABLE_BIT: assert property (@(posedge clk) disable iff (!arst_n)
        start_req && !hwdata[`PFSW_WRITE_ENABLE_BIT_BIT] |=> seq == pfsw_pkg::SEQ_IDLE && !cpu_stall)
        else $error("operation started without write enable");

    AST_INTERVENE: assert property (@(posedge clk) disable iff (!arst_n)
        wr && !sel_key |=> key_st == pfsw_pkg::KEY_NONE)
        else $error("unlock survived an intervening write");

    AST_STALL: assert property (@(posedge clk) disable iff (!arst_n)
        launch |=> cpu_stall[*8] ##0 (seq == pfsw_pkg::SEQ_BUSY))
        else $error("processor not stalled during operation");

    AST_START_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        done |-> flash_control_reg.start ##1 (!flash_control_reg.start && !cpu_stall))
        else $error("start bit not cleared at completion");

    AST_CAPTURE: assert property (@(posedge clk) disable iff (!arst_n)
        tbl_acc |=> {flash_addr_high_reg, flash_addr_low_reg}
                    == {$past(table_page_pointer), $past(tbl_ea)})
        else $error("table address not captured");

    AST_TBL_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
        accept && seq == pfsw_pkg::SEQ_IDLE && !launch |=> !hreadyout ##1 hreadyout)
        else $error("table access did not finish in two cycles");

    AST_HI_BYTE: assert property (@(posedge clk) disable iff (!arst_n)
        tbl_wr_hi && !odd_byte |=> wr_latch[$past(lat_pan)][$past(lat_idx)][23:16]
                                   == $past(hwdata[7:0]))
        else $error("high latch write took the wrong byte");

endmodule : pfsw_top

`default_nettype wire
